// ===== logic/fast_settling_average_filter.sv
module fast_settling_average_filter
  import fast_settle_pkg::*;
(
  input  wire logic                                    core_clk,
  input  wire logic                                    resetn,
  input  wire logic                                    clk_en,
  input  wire fast_settle_pkg::filter_config_type      cfg,
  input  wire logic                                    channel_change,
  input  wire logic                                    mod_valid,
  input  wire logic signed [fast_settle_pkg::MOD_WIDTH-1:0] mod_sample,
  output logic                                         mod_ready,
  output logic                                         chop_polarity,
  output logic                                         fast_settle_active,
  output fast_settle_pkg::result_word_type             result_data,
  output logic                                         result_valid,
  input  wire logic                                    result_ready
);
  import fast_settle_pkg::*;

  // averaging count from the two select bits
  function automatic logic [4:0] avg_count(input logic [1:0] code);
    logic [4:0] n;
    n = AVG_1_COUNT;
    if (code == AVG_2_CODE) begin
      n = AVG_2_COUNT;
    end else if (code == AVG_8_CODE) begin
      n = AVG_8_COUNT;
    end else if (code == AVG_16_CODE) begin
      n = AVG_16_COUNT;
    end
    return n;
  endfunction : avg_count

  // decimation length of one sinc word in modulator samples taken
  function automatic logic [CNT_WIDTH-1:0] block_len(input logic [RATE_WIDTH-1:0] word);
    return CNT_WIDTH'({word, {SINC_BLOCK_LOG2{1'b0}}});
  endfunction : block_len

  // warm-up words that the sinc order needs before averaging starts
  function automatic logic [4:0] warm_count(input logic fast, input logic sinc4);
    logic [4:0] w;
    w = 5'h00;
    if (fast) begin
      w = (sinc4 ? 5'(SINC4_ORDER) : 5'(SINC3_ORDER)) - 5'h01;
    end
    return w;
  endfunction : warm_count

  // output periods a fresh conversion needs before its result is settled
  function automatic logic [1:0] settle_need(input logic chop);
    logic [1:0] p;
    p = PLAIN_SETTLE_PERIODS;
    if (chop) begin
      p = CHOP_SETTLE_PERIODS;
    end
    return p;
  endfunction : settle_need

  wire [1:0]           avg_code     = {cfg.average_select_high, cfg.average_select_low};
  wire                 fast_on      = (avg_code != AVG_OFF_CODE);
  wire [4:0]           avg_n        = avg_count(avg_code);
  // the sixty hz bit is not read here; words per result stay as order and averaging set them
  wire [4:0]           warm_words   = warm_count(fast_on, cfg.sinc4_select);
  // words per result: warm words ((order - 1) in fast settling, none otherwise) plus avg words
  wire [5:0]           words_total  = 6'(warm_words) + 6'(avg_n);
  wire [CNT_WIDTH-1:0] blk_len      = block_len(cfg.filter_rate_word);
  wire                 word_zero    = (cfg.filter_rate_word == {RATE_WIDTH{1'b0}});

  phase_type                  phase;
  phase_type                  next_phase;
  logic [CNT_WIDTH-1:0]       sample_cnt;
  logic [5:0]                 word_cnt;
  logic signed [47:0]         block_acc;
  logic signed [47:0]         avg_acc;
  logic signed [47:0]         chop_prev;
  logic                       chop_have_prev;
  logic [1:0]                 conv_done;
  logic                       pending_valid;
  result_word_type            pending_word;

  // two-entry output buffer
  result_word_type            buf_mem [0:1];
  logic                       wr_ptr;
  logic                       rd_ptr;
  logic [1:0]                 buf_count;

  wire buf_full   = (buf_count == 2'h2);
  wire buf_push   = pending_valid && !buf_full;
  wire buf_pop    = result_valid && result_ready;
  wire block_end  = (sample_cnt == blk_len - CNT_WIDTH'(1));
  wire take       = mod_valid && mod_ready;
  wire in_avg     = (word_cnt >= 6'(warm_words));
  wire last_word  = (word_cnt == words_total - 6'h01);

  // stall the modulator while a finished result waits for buffer space
  assign mod_ready          = clk_en && !pending_valid && !word_zero;
  assign result_valid       = (buf_count != 2'h0);
  assign result_data        = buf_mem[rd_ptr];
  assign fast_settle_active = fast_on;

  // signed sample with chop polarity removed
  wire signed [47:0]      signed_sample   = chop_polarity ? -48'(mod_sample) : 48'(mod_sample);
  wire signed [47:0]      block_sum       = block_acc + signed_sample;
  wire signed [47:0]      avg_sum         = avg_acc + (in_avg ? block_sum : 48'sh0);
  // chop result averages the two opposite-polarity conversions
  wire signed [47:0]      chop_mean       = (chop_prev + avg_sum) >>> 1;
  // last sample of the last word of a result
  wire                    emit_now        = take && block_end && last_word;
  // a restart in the same cycle wins over a finishing conversion
  wire                    emit_ok         = emit_now && !channel_change;
  wire [1:0]              settle_periods  = settle_need(cfg.chop_enable);
  wire                    conv_full       = (conv_done >= settle_periods);
  // chop needs a pair before its first output, doubling settling
  wire                    chop_gate       = (conv_done + 2'h1 >= settle_periods)
                                            && (!cfg.chop_enable || chop_have_prev);
  wire                    result_made     = emit_ok && chop_gate;
  // accumulators move only on a taken sample that is not a restart
  wire                    sample_step     = take && !channel_change;
  wire                    word_step       = sample_step && block_end;

  // counters wrap at the end of a word and at the end of a result
  wire [CNT_WIDTH-1:0]    next_sample_cnt = block_end ? {CNT_WIDTH{1'b0}} : sample_cnt + CNT_WIDTH'(1);
  wire [5:0]              next_word_cnt   = last_word ? 6'h00 : word_cnt + 6'h01;

  // accumulators restart from zero with each new word or result
  wire signed [47:0]      next_block_acc  = block_end ? 48'sh0 : block_sum;
  wire signed [47:0]      next_avg_acc    = last_word ? 48'sh0 : avg_sum;

  // polarity swaps after every conversion while chop is on
  wire                    next_polarity   = cfg.chop_enable ? !chop_polarity : 1'b0;
  // chop output is the mean of a pair, otherwise the plain sum of the averaging words
  wire [RESULT_WIDTH-1:0] next_value      = RESULT_WIDTH'(cfg.chop_enable ? chop_mean : avg_sum);
  wire [1:0]              next_buf_count  = buf_count + 2'(buf_push) - 2'(buf_pop);

  // phase follows the conversion: warm-up words, averaging, hand-over
  always_comb begin
    next_phase = phase;
    case (phase)
      FILL_STATE: begin
        if (emit_ok) begin
          next_phase = EMIT_STATE;
        end else if (sample_step && in_avg) begin
          next_phase = AVERAGE_STATE;
        end
      end
      AVERAGE_STATE: begin
        if (emit_ok) begin
          next_phase = EMIT_STATE;
        end
      end
      // a skipped chop result leaves nothing to push
      EMIT_STATE: begin
        if (buf_push || !pending_valid) begin
          next_phase = FILL_STATE;
        end
      end
      default: begin
        next_phase = FILL_STATE;
      end
    endcase
    if (channel_change) begin
      next_phase = FILL_STATE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      phase <= FILL_STATE;
    end else if (clk_en) begin
      phase <= next_phase;
    end
  end

  // a channel change restarts the conversion: full settled result next
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sample_cnt <= '0;
    end else if (clk_en) begin
      if (channel_change) begin
        sample_cnt <= '0;
      end else if (take) begin
        sample_cnt <= next_sample_cnt;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      block_acc <= '0;
    end else if (clk_en) begin
      if (channel_change) begin
        block_acc <= '0;
      end else if (take) begin
        block_acc <= next_block_acc;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      word_cnt <= '0;
    end else if (clk_en) begin
      if (channel_change) begin
        word_cnt <= '0;
      end else if (word_step) begin
        word_cnt <= next_word_cnt;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      avg_acc <= '0;
    end else if (clk_en) begin
      if (channel_change) begin
        avg_acc <= '0;
      end else if (word_step) begin
        avg_acc <= next_avg_acc;
      end
    end
  end

  // conversions since restart, held once the settling need is met
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      conv_done <= 2'h0;
    end else if (clk_en) begin
      if (channel_change) begin
        conv_done <= 2'h0;
      end else if (emit_ok && !conv_full) begin
        conv_done <= conv_done + 2'h1;
      end
    end
  end

  // previous conversion kept for the chop pair
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      chop_prev <= '0;
    end else if (clk_en) begin
      if (emit_ok) begin
        chop_prev <= avg_sum;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      chop_have_prev <= 1'b0;
    end else if (clk_en) begin
      if (channel_change) begin
        chop_have_prev <= 1'b0;
      end else if (emit_ok) begin
        chop_have_prev <= cfg.chop_enable;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      chop_polarity <= 1'b0;
    end else if (clk_en) begin
      if (emit_ok) begin
        chop_polarity <= next_polarity;
      end
    end
  end

  // a finished result waits here until the buffer takes it
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pending_valid <= 1'b0;
    end else if (clk_en) begin
      if (result_made) begin
        pending_valid <= 1'b1;
      end else if (buf_push) begin
        pending_valid <= 1'b0;
      end
    end
  end

  // input steps are invisible here, so every result is flagged settled
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pending_word <= '{value: RESULT_RESET, settled: 1'b0};
    end else if (clk_en) begin
      if (result_made) begin
        pending_word <= '{value: next_value, settled: 1'b1};
      end
    end
  end

  // two-entry output buffer
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      buf_mem[0] <= '{value: RESULT_RESET, settled: 1'b0};
      buf_mem[1] <= '{value: RESULT_RESET, settled: 1'b0};
    end else if (clk_en) begin
      if (buf_push) begin
        buf_mem[wr_ptr] <= pending_word;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wr_ptr <= 1'b0;
    end else if (clk_en) begin
      if (buf_push) begin
        wr_ptr <= !wr_ptr;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rd_ptr <= 1'b0;
    end else if (clk_en) begin
      if (buf_pop) begin
        rd_ptr <= !rd_ptr;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      buf_count <= 2'h0;
    end else if (clk_en) begin
      buf_count <= next_buf_count;
    end
  end

endmodule : fast_settling_average_filter

// ===== common/fast_settle_pkg.sv
package fast_settle_pkg;

  // modulator and result widths
  localparam int unsigned MOD_WIDTH       = 24;
  localparam int unsigned RESULT_WIDTH    = 32;
  localparam int unsigned RATE_WIDTH      = 10;
  localparam int unsigned SINC_BLOCK      = 1024;
  localparam int unsigned SINC_BLOCK_LOG2 = 10;
  localparam int unsigned CNT_WIDTH       = 20;
  localparam int unsigned AVG_CNT_WIDTH   = 5;

  // master clock nominal frequency in hz
  localparam int unsigned MASTER_CLOCK_HZ = 4920000;

  // sinc orders; the order adds (order - 1) warm-up sinc words in fast settling
  localparam logic [2:0] SINC3_ORDER = 3'h3;
  localparam logic [2:0] SINC4_ORDER = 3'h4;

  // averaging encodings of {average_select_high, average_select_low}
  localparam logic [1:0] AVG_OFF_CODE = 2'h0;
  localparam logic [1:0] AVG_2_CODE   = 2'h1;
  localparam logic [1:0] AVG_8_CODE   = 2'h2;
  localparam logic [1:0] AVG_16_CODE  = 2'h3;
  localparam logic [4:0] AVG_2_COUNT  = 5'h02;
  localparam logic [4:0] AVG_8_COUNT  = 5'h08;
  localparam logic [4:0] AVG_16_COUNT = 5'h10;
  localparam logic [4:0] AVG_1_COUNT  = 5'h01;

  // chop settles over two output periods
  localparam logic [1:0] CHOP_SETTLE_PERIODS  = 2'h2;
  localparam logic [1:0] PLAIN_SETTLE_PERIODS = 2'h1;

  // reset values
  localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [RATE_WIDTH-1:0] filter_rate_word;
    logic                  average_select_high;
    logic                  average_select_low;
    logic                  sixty_hz_notch_enable;
    logic                  sinc4_select;
    logic                  chop_enable;
  } filter_config_type;

  typedef struct packed {
    logic [RESULT_WIDTH-1:0] value;
    logic                    settled;
  } result_word_type;

  typedef enum logic [1:0] {
    FILL_STATE   = 2'b00,
    AVERAGE_STATE = 2'b01,
    EMIT_STATE   = 2'b10
  } phase_type;

endpackage : fast_settle_pkg

// ===== bench/fast_settle_checker.sv
module fast_settle_checker
  import fast_settle_pkg::*;
(
  input wire logic                               core_clk,
  input wire logic                               resetn,
  input wire logic                               clk_en,
  input wire fast_settle_pkg::filter_config_type cfg,
  input wire logic                               mod_ready,
  input wire logic                               chop_polarity,
  input wire logic                               fast_settle_active,
  input wire fast_settle_pkg::result_word_type   result_data,
  input wire logic                               result_valid,
  input wire logic                               result_ready
);
  default clocking @(posedge core_clk); endclocking

  chk_valid_hold: assert property (disable iff (!resetn)
    result_valid && !result_ready && clk_en |=> result_valid && $stable(result_data))
    else $error("result dropped or changed before pop");
  chk_fast_active: assert property (fast_settle_active == (cfg.average_select_high | cfg.average_select_low))
    else $error("fast settling flag does not follow averaging code");
  chk_reset_clear: assert property (!resetn && clk_en |=> !result_valid && !chop_polarity)
    else $error("reset left result or polarity set");
  chk_word_zero: assert property (cfg.filter_rate_word == 10'h000 |-> !mod_ready)
    else $error("samples accepted with zero rate word");
  chk_freeze_state: assert property (disable iff (!resetn)
    !clk_en |=> $stable(result_valid) && $stable(chop_polarity))
    else $error("state moved while clock enable low");
  chk_settled_flag: assert property (disable iff (!resetn) result_valid |-> result_data.settled)
    else $error("unsettled result presented");
  chk_reset_ready: assert property ((!resetn && clk_en) ##1 (clk_en && cfg.filter_rate_word != 10'h000)
    |-> mod_ready)
    else $error("not ready for samples after reset");
  chk_early_result: assert property ($rose(resetn) |-> !result_valid [*8])
    else $error("result appeared right after reset");

  cover property (result_valid && result_ready);
  cover property ($rose(chop_polarity));
  cover property (resetn && clk_en && !mod_ready);
endmodule : fast_settle_checker

// ===== bench/fast_settling_average_filter_tb.sv
module fast_settling_average_filter_tb import fast_settle_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic                          core_clk = 1'b0;
  logic                          resetn = 1'b0;
  logic                          clk_en = 1'b1;
  logic                          channel_change = 1'b0;
  logic                          mod_valid = 1'b0;
  logic                          result_ready = 1'b0;
  logic signed [MOD_WIDTH-1:0]   mod_sample = 24'h5a5a5a;
  filter_config_type             cfg = 15'h0020;
  logic                          mod_ready, chop_polarity, fast_settle_active, result_valid, pol;
  result_word_type               result_data;
  int                            errors = 0, compares = 0, cycles = 0;
  filter_config_type             list [6];

  fast_settling_average_filter u_fast_settling_average_filter (.core_clk(core_clk), .resetn(resetn),
    .clk_en(clk_en), .cfg(cfg), .channel_change(channel_change), .mod_valid(mod_valid),
    .mod_sample(mod_sample), .mod_ready(mod_ready), .chop_polarity(chop_polarity),
    .fast_settle_active(fast_settle_active), .result_data(result_data), .result_valid(result_valid),
    .result_ready(result_ready));

  initial forever #4 core_clk = ~core_clk;
  always @(negedge core_clk) mod_sample <= ~mod_sample;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 80000) begin
      errors++;
      end_of_test();
    end
  end

  function automatic filter_config_type mk(input logic [9:0] w, input logic [1:0] a, input logic x, s4, ch);
    mk = {w, a, x, s4, ch};
  endfunction : mk

  // samples per result: (warm + average) blocks of 1024 times the rate word
  function automatic int nexp(input filter_config_type c);
    int avg;
    int warm;
    avg = 1;
    warm = 0;
    case ({c.average_select_high, c.average_select_low})
      2'h1: avg = 2;
      2'h2: avg = 8;
      2'h3: avg = 16;
      default: avg = 1;
    endcase
    if (avg > 1) warm = c.sinc4_select ? 3 : 2;
    return (warm + avg) * 1024 * int'(c.filter_rate_word);
  endfunction : nexp

  task automatic check(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : check

  task automatic feed(input int n);
    int k;
    k = 0;
    mod_valid = 1'b1;
    // ready seen at the falling edge stands through the next rising edge
    while (k < n) begin
      if (mod_ready === 1'b1) k++;
      @(negedge core_clk);
    end
    mod_valid = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask : feed

  task automatic got(input string name);
    check(result_valid, 1'b1, {name, " result missing"});
    check(result_data.settled, 1'b1, {name, " not settled"});
    result_ready = 1'b1;
    @(negedge core_clk);
    result_ready = 1'b0;
    @(negedge core_clk);
    check(result_valid, 1'b0, {name, " not popped"});
    $display("test %s done", name);
  endtask : got

  task automatic run(input filter_config_type c, input string name);
    cfg = c;
    channel_change = 1'b1;
    @(negedge core_clk);
    channel_change = 1'b0;
    check(fast_settle_active, c.average_select_high | c.average_select_low, {name, " mode flag"});
    pol = chop_polarity;
    feed(nexp(c) - 1);
    check(result_valid, 1'b0, {name, " result early"});
    feed(1);
  endtask : run

  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (8) @(negedge core_clk);
    resetn = 1'b1;
    check(result_valid, 1'b0, "reset result");
    check(chop_polarity, 1'b0, "reset polarity");
    clk_en = 1'b0;
    repeat (3) @(negedge core_clk);
    clk_en = 1'b1;
    run(mk(10'd1, 2'h1, 1'b0, 1'b0, 1'b0), "avg2");
    got("avg2");
    feed(4096);
    got("second period");
    list = '{mk(10'd1, 2'h2, 1'b0, 1'b0, 1'b0), mk(10'd1, 2'h3, 1'b0, 1'b0, 1'b0),
             mk(10'd1, 2'h0, 1'b0, 1'b0, 1'b0), mk(10'd1, 2'h1, 1'b1, 1'b0, 1'b0),
             mk(10'd1, 2'h1, 1'b0, 1'b1, 1'b0), mk(10'd2, 2'h1, 1'b0, 1'b0, 1'b0)};
    foreach (list[i]) begin
      run(list[i], $sformatf("config %0d", i));
      got("config");
    end
    run(mk(10'd1, 2'h1, 1'b0, 1'b0, 1'b1), "chop");
    check(result_valid, 1'b0, "chop first result skipped");
    check(chop_polarity, ~pol, "chop polarity reversed");
    feed(4096);
    got("chop");
    cfg = mk(10'd0, 2'h1, 1'b0, 1'b0, 1'b0);
    @(negedge core_clk);
    check(mod_ready, 1'b0, "zero word accepted");
    $display("test zero word done");
    end_of_test();
  end
endmodule : fast_settling_average_filter_tb

bind fast_settling_average_filter fast_settle_checker u_fast_settle_checker (.core_clk(core_clk), .resetn(resetn),
  .clk_en(clk_en), .cfg(cfg), .mod_ready(mod_ready), .chop_polarity(chop_polarity),
  .fast_settle_active(fast_settle_active), .result_data(result_data), .result_valid(result_valid),
  .result_ready(result_ready));
